// File: hw/plr_defines.vh
`ifndef PLR_DEFINES_VH
`define PLR_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PLR_OFS_CTRL 4'h0
`define PLR_OFS_RIDE 4'h1
`define PLR_OFS_BLOCK 4'h2
`define PLR_OFS_RECOV 4'h3
`define PLR_OFS_UVLVL 4'h4
`define PLR_OFS_STATUS 4'h5
`define PLR_OFS_IRQ_STAT 4'h6
`define PLR_OFS_IRQ_MASK 4'h7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PLR_CTRL_MODE_LSB 0
`define PLR_CTRL_FCLR_BIT 4
`define PLR_IRQ_LOSS_BIT 0
`define PLR_IRQ_RESTART_BIT 1
`define PLR_IRQ_FAULT_BIT 2

// ----------------------------------------
// Reset values and limits (times in 0.1 s)
// ----------------------------------------
`define PLR_MODE_RST 2'h0
`define PLR_MODE_MAX 2'h2
`define PLR_RIDE_RST 6'h01
`define PLR_RIDE_MAX 6'h14
`define PLR_BLOCK_RST 6'h01
`define PLR_BLOCK_MIN 6'h01
`define PLR_BLOCK_MAX 6'h32
`define PLR_RECOV_RST 6'h03
`define PLR_RECOV_MAX 6'h32
`define PLR_UV_RST_V 190
`define PLR_UV_MIN_V 150
`define PLR_UV_MAX_V 210

// ----------------------------------------
// Timing
// ----------------------------------------
`define PLR_CLK_NS 10
`define PLR_TICK_NS 1000000
`define PLR_TICK_CYCLES (`PLR_TICK_NS / `PLR_CLK_NS)
`define PLR_DIP_MS 15
`define PLR_MS_PER_UNIT 13'h0064

`endif

// File: hw/plr_sync.v
`timescale 1ns/100ps
module plr_sync #(
  parameter WIDTH = 2
) (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Asynchronous inputs and clean result
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] s1_q;
reg [WIDTH-1:0] s2_q;
reg [WIDTH-1:0] s3_q;
integer i;

// ----------------------------------------
// Three stages; a change counts once stages two and three agree
// ----------------------------------------
always @(posedge clk or negedge arst_n) begin
  if (!arst_n) begin
    s1_q <= {WIDTH{1'b0}};
    s2_q <= {WIDTH{1'b0}};
    s3_q <= {WIDTH{1'b0}};
    sync_out <= {WIDTH{1'b0}};
  end else begin
    s1_q <= async_in;
    s2_q <= s1_q;
    s3_q <= s2_q;
    for (i = 0; i < WIDTH; i = i + 1) begin
      if (s2_q[i] == s3_q[i]) begin
        sync_out[i] <= s3_q[i];
      end
    end
  end
end

endmodule // plr_sync

// File: hw/plr_tick.v
`timescale 1ns/100ps
module plr_tick #(
  parameter CYCLES = 100000
) (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // One-cycle enable every CYCLES clocks
  output reg tick
);

localparam [19:0] LAST = CYCLES - 1;

reg [19:0] cnt_q;

always @(posedge clk or negedge arst_n) begin
  if (!arst_n) begin
    cnt_q <= 20'h00000;
    tick <= 1'b0;
  end else if (cnt_q == LAST) begin
    cnt_q <= 20'h00000;
    tick <= 1'b1;
  end else begin
    cnt_q <= cnt_q + 20'h00001;
    tick <= 1'b0;
  end
end

endmodule // plr_tick

// File: hw/plr_ctrl.v
`timescale 1ns/100ps
`include "plr_defines.vh"
module plr_ctrl #(
  parameter TICK_CYCLES = `PLR_TICK_CYCLES,
  parameter HV_CLASS = 0,
  parameter VW = 10,
  parameter SCALE_W = 8
) (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Register port
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata_q,
  // Supply and drive inputs
  input wire [VW-1:0] bus_volt,
  input wire ctrl_power_ok,
  input wire run_cmd,
  input wire drive_err,
  // Drive outputs
  output reg output_block_q,
  output reg [SCALE_W-1:0] volt_scale_q,
  output reg bus_undervoltage_q,
  output reg bus_undervoltage_fault_q,
  output reg err_out_q,
  output reg irq_q
);

// ----------------------------------------
// States
// ----------------------------------------
localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_RUN = 3'h1;
localparam [2:0] ST_LOSS = 3'h2;
localparam [2:0] ST_BLOCK = 3'h3;
localparam [2:0] ST_RAMP = 3'h4;
localparam [2:0] ST_FAULT = 3'h5;

localparam [VW-1:0] UV_MUL = (HV_CLASS != 0) ? 2 : 1;
localparam [VW-1:0] UV_RST = `PLR_UV_RST_V * UV_MUL;
localparam [VW-1:0] UV_MIN = `PLR_UV_MIN_V * UV_MUL;
localparam [VW-1:0] UV_MAX = `PLR_UV_MAX_V * UV_MUL;
localparam [12:0] DIP_MS = `PLR_DIP_MS;
localparam [SCALE_W-1:0] SCALE_MAX = {SCALE_W{1'b1}};

// Setting in 0.1 s units to milliseconds
function [12:0] to_ms;
  input [5:0] units;
  begin
    to_ms = {7'h00, units} * `PLR_MS_PER_UNIT;
  end
endfunction

function [5:0] clamp6;
  input [5:0] v;
  input [5:0] lo;
  input [5:0] hi;
  begin
    clamp6 = (v < lo) ? lo : ((v > hi) ? hi : v);
  end
endfunction

// ----------------------------------------
// Input conditioning and ms timebase
// ----------------------------------------
wire [1:0] pins_s;
wire ms_tick;
wire ctrl_ok_s = pins_s[0];
wire run_s = pins_s[1];

plr_sync #(
  .WIDTH(2)
) u_sync (
  .clk(clk),
  .arst_n(arst_n),
  .async_in({run_cmd, ctrl_power_ok}),
  .sync_out(pins_s)
);

// The timebase free-runs, so any timer may see its first tick
// up to one ms early; outage limits are minimums, block and ramp may end up to one ms short.
plr_tick #(
  .CYCLES(TICK_CYCLES)
) u_tick (
  .clk(clk),
  .arst_n(arst_n),
  .tick(ms_tick)
);

// ----------------------------------------
// Registers
// ----------------------------------------
reg [1:0] mode_q;
reg [5:0] ride_q;
reg [5:0] block_q;
reg [5:0] recov_q;
reg [VW-1:0] uvlvl_q;
reg [2:0] irq_stat_q;
reg [2:0] irq_mask_q;
reg fault_clr_q;
reg [2:0] state_q;
reg [2:0] state_d;
reg [12:0] outage_ms_q;
reg [12:0] block_ms_q;
reg [12:0] acc_q;
reg ev_loss;
reg ev_restart;
reg ev_fault;

wire bus_uv = bus_volt < uvlvl_q;
wire [12:0] ride_ms = to_ms(ride_q);
wire [12:0] block_min_ms = to_ms(block_q);
wire [12:0] recov_ms = to_ms(recov_q);
wire wr_ctrl = reg_wr && (reg_addr == `PLR_OFS_CTRL);
// Masking follows the next state so the first loss cycle
// already hides drive errors from the error output.
wire recovering = (state_d == ST_LOSS) || (state_d == ST_BLOCK) || (state_d == ST_RAMP);

always @(posedge clk or negedge arst_n) begin
  if (!arst_n) begin
    mode_q <= `PLR_MODE_RST;
    ride_q <= `PLR_RIDE_RST;
    block_q <= `PLR_BLOCK_RST;
    recov_q <= `PLR_RECOV_RST;
    uvlvl_q <= UV_RST;
    irq_mask_q <= 3'h0;
    fault_clr_q <= 1'b0;
  end else begin
    fault_clr_q <= wr_ctrl && reg_wdata[`PLR_CTRL_FCLR_BIT];
    if (reg_wr) begin
      case (reg_addr)
        `PLR_OFS_CTRL: begin
          // Out-of-range modes are ignored, leaving the previous one
          if (reg_wdata[`PLR_CTRL_MODE_LSB +: 2] <= `PLR_MODE_MAX) begin
            mode_q <= reg_wdata[`PLR_CTRL_MODE_LSB +: 2];
          end
        end
        `PLR_OFS_RIDE: begin
          ride_q <= clamp6(reg_wdata[5:0] | {6{|reg_wdata[15:6]}}, 6'h00,
                           `PLR_RIDE_MAX);
        end
        `PLR_OFS_BLOCK: begin
          block_q <= clamp6(reg_wdata[5:0] | {6{|reg_wdata[15:6]}}, `PLR_BLOCK_MIN,
                            `PLR_BLOCK_MAX);
        end
        `PLR_OFS_RECOV: begin
          recov_q <= clamp6(reg_wdata[5:0] | {6{|reg_wdata[15:6]}}, 6'h00,
                            `PLR_RECOV_MAX);
        end
        `PLR_OFS_UVLVL: begin
          if (reg_wdata < {{(16-VW){1'b0}}, UV_MIN}) begin
            uvlvl_q <= UV_MIN;
          end else if (reg_wdata > {{(16-VW){1'b0}}, UV_MAX}) begin
            uvlvl_q <= UV_MAX;
          end else begin
            uvlvl_q <= reg_wdata[VW-1:0];
          end
        end
        `PLR_OFS_IRQ_MASK: begin
          irq_mask_q <= reg_wdata[2:0];
        end
        default: begin
        end
      endcase
    end
  end
end

// ----------------------------------------
// Sequencer
// ----------------------------------------
always @* begin
  state_d = state_q;
  ev_loss = 1'b0;
  ev_restart = 1'b0;
  ev_fault = 1'b0;
  case (state_q)
    ST_IDLE: begin
      if (run_s && ctrl_ok_s && !bus_uv) begin
        state_d = ST_RUN;
      end
    end
    ST_RUN, ST_RAMP: begin
      if (bus_uv) begin
        state_d = ST_LOSS;
        ev_loss = 1'b1;
      end else if (!run_s) begin
        state_d = ST_IDLE;
      end else if (state_q == ST_RAMP && volt_scale_q == SCALE_MAX) begin
        state_d = ST_RUN;
      end
    end
    ST_LOSS: begin
      if (mode_q == 2'h0 && outage_ms_q > DIP_MS) begin
        state_d = ST_FAULT;
        ev_fault = 1'b1;
      end else if (mode_q == 2'h1 && outage_ms_q > ride_ms) begin
        state_d = ST_FAULT;
        ev_fault = 1'b1;
      end else if (mode_q == 2'h2 && !ctrl_ok_s) begin
        state_d = ST_IDLE;
      end else if (!bus_uv) begin
        state_d = ST_BLOCK;
      end
    end
    ST_BLOCK: begin
      if (bus_uv) begin
        state_d = ST_LOSS;
      end else if (!run_s) begin
        state_d = ST_IDLE;
      end else if (block_ms_q >= block_min_ms) begin
        state_d = ST_RAMP;
        ev_restart = 1'b1;
      end
    end
    ST_FAULT: begin
      if (fault_clr_q) begin
        state_d = ST_IDLE;
      end
    end
    default: begin
      state_d = ST_IDLE;
    end
  endcase
end

always @(posedge clk or negedge arst_n) begin
  if (!arst_n) begin
    state_q <= ST_IDLE;
    outage_ms_q <= 13'h0000;
    block_ms_q <= 13'h0000;
  end else begin
    state_q <= state_d;
    // Outage time restarts on each fresh drop below the threshold
    if (state_q != ST_LOSS) begin
      outage_ms_q <= 13'h0000;
    end else if (ms_tick && outage_ms_q != 13'h1fff) begin
      outage_ms_q <= outage_ms_q + 13'h0001;
    end
    // Block time runs from the first drop until the restart
    if (state_q != ST_LOSS && state_q != ST_BLOCK) begin
      block_ms_q <= 13'h0000;
    end else if (ms_tick && block_ms_q != 13'h1fff) begin
      block_ms_q <= block_ms_q + 13'h0001;
    end
  end
end

// ----------------------------------------
// Voltage recovery ramp
// ----------------------------------------
// Bresenham stepping: SCALE_MAX steps spread over recov_ms ticks,
// so no divider is needed for any recovery time.
always @(posedge clk or negedge arst_n) begin
  if (!arst_n) begin
    volt_scale_q <= {SCALE_W{1'b0}};
    acc_q <= 13'h0000;
  end else if (state_q == ST_RUN) begin
    volt_scale_q <= SCALE_MAX;
    acc_q <= 13'h0000;
  end else if (state_q != ST_RAMP) begin
    volt_scale_q <= {SCALE_W{1'b0}};
    acc_q <= 13'h0000;
  end else if (recov_ms == 13'h0000) begin
    volt_scale_q <= SCALE_MAX;
  end else if (acc_q >= recov_ms && volt_scale_q != SCALE_MAX) begin
    volt_scale_q <= volt_scale_q + {{(SCALE_W-1){1'b0}}, 1'b1};
    acc_q <= acc_q - recov_ms;
  end else if (ms_tick) begin
    acc_q <= acc_q + {{(13-SCALE_W){1'b0}}, SCALE_MAX};
  end
end

// ----------------------------------------
// Outputs and interrupts
// ----------------------------------------
wire [2:0] ev_vec = {ev_fault, ev_restart, ev_loss};
wire irq_clr_wr = reg_wr && (reg_addr == `PLR_OFS_IRQ_STAT);
wire [2:0] irq_clr = irq_clr_wr ? reg_wdata[2:0] : 3'h0;

always @(posedge clk or negedge arst_n) begin
  if (!arst_n) begin
    output_block_q <= 1'b1;
    bus_undervoltage_q <= 1'b0;
    bus_undervoltage_fault_q <= 1'b0;
    err_out_q <= 1'b0;
    irq_stat_q <= 3'h0;
    irq_q <= 1'b0;
  end else begin
    output_block_q <= (state_d != ST_RUN) && (state_d != ST_RAMP);
    bus_undervoltage_q <= bus_uv;
    bus_undervoltage_fault_q <= (state_d == ST_FAULT);
    err_out_q <= (state_d == ST_FAULT) || (drive_err && !recovering);
    // A new event wins over a clear in the same cycle
    irq_stat_q <= (irq_stat_q & ~irq_clr) | ev_vec;
    irq_q <= |(((irq_stat_q & ~irq_clr) | ev_vec) & irq_mask_q);
  end
end

// ----------------------------------------
// Read port
// ----------------------------------------
always @(posedge clk or negedge arst_n) begin
  if (!arst_n) begin
    reg_rdata_q <= 16'h0000;
  end else if (reg_rd) begin
    case (reg_addr)
      `PLR_OFS_CTRL: reg_rdata_q <= {14'h0000, mode_q};
      `PLR_OFS_RIDE: reg_rdata_q <= {10'h000, ride_q};
      `PLR_OFS_BLOCK: reg_rdata_q <= {10'h000, block_q};
      `PLR_OFS_RECOV: reg_rdata_q <= {10'h000, recov_q};
      `PLR_OFS_UVLVL: reg_rdata_q <= {{(16-VW){1'b0}}, uvlvl_q};
      `PLR_OFS_STATUS: begin
        reg_rdata_q <= {8'h00, output_block_q, bus_undervoltage_fault_q,
                        bus_uv, ctrl_ok_s, run_s, state_q};
      end
      `PLR_OFS_IRQ_STAT: reg_rdata_q <= {13'h0000, irq_stat_q};
      `PLR_OFS_IRQ_MASK: reg_rdata_q <= {13'h0000, irq_mask_q};
      default: reg_rdata_q <= 16'h0000;
    endcase
  end else begin
    reg_rdata_q <= 16'h0000;
  end
end

endmodule // plr_ctrl

// File: tb/plr_ctrl_sva.sv
`timescale 1ns/100ps
module plr_ctrl_sva #(
  parameter TICK_CYCLES = 10,
  parameter HV_CLASS = 0,
  parameter VW = 10,
  parameter SCALE_W = 8
) (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Register port
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata_q,
  // Supply and drive
  input wire [VW-1:0] bus_volt,
  input wire ctrl_power_ok,
  input wire run_cmd,
  input wire drive_err,
  input wire output_block_q,
  input wire [SCALE_W-1:0] volt_scale_q,
  input wire bus_undervoltage_q,
  input wire bus_undervoltage_fault_q,
  input wire err_out_q,
  input wire irq_q
);
  // Early first tick may shorten the block by up to one ms
  localparam integer MINC = 99 * TICK_CYCLES - 2;
  wire clr_wr = reg_wr && reg_addr == 4'h0 && reg_wdata[4];
  reg [31:0] cnt_q;
  reg armed_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // Time since the last outage began
  // ----------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 32'h0;
      armed_q <= 1'b0;
    end else begin
      cnt_q <= $rose(bus_undervoltage_q) ? 32'h0 : cnt_q + 32'h1;
      if ($rose(bus_undervoltage_q) && !$past(output_block_q))
        armed_q <= 1'b1;
      else if ($fell(output_block_q) || bus_undervoltage_fault_q || !ctrl_power_ok)
        armed_q <= 1'b0;
    end
  end
  chk_uv_low: assert property (
    bus_volt < 10'h096 |=> bus_undervoltage_q) else $error("uv missed");
  chk_uv_high: assert property (
    bus_volt > 10'h0d2 |=> !bus_undervoltage_q) else $error("uv stuck");
  chk_fault_err: assert property (
    $rose(bus_undervoltage_fault_q) |-> ##[0:1] err_out_q) else $error("fault not output");
  chk_fault_cause: assert property (
    $rose(bus_undervoltage_fault_q) |-> $past(bus_undervoltage_q)) else $error("fault no uv");
  chk_fault_hold: assert property (
    $fell(bus_undervoltage_fault_q) |-> $past(clr_wr) || $past(clr_wr, 2) || $past(clr_wr, 3))
    else $error("fault dropped alone");
  chk_loss_block: assert property (
    $rose(bus_undervoltage_q) && !$past(output_block_q) |-> ##[0:1] output_block_q)
    else $error("no block on loss");
  chk_block_min: assert property (
    $fell(output_block_q) && armed_q |-> cnt_q >= MINC) else $error("block too short");
  chk_ramp_up: assert property (
    !output_block_q && !$past(output_block_q) |-> volt_scale_q >= $past(volt_scale_q))
    else $error("ramp fell");
  chk_err_masked: assert property (
    !output_block_q && volt_scale_q != 8'hff && !bus_undervoltage_fault_q |-> !err_out_q)
    else $error("error during recovery");
endmodule // plr_ctrl_sva

bind plr_ctrl plr_ctrl_sva #(.TICK_CYCLES(TICK_CYCLES), .HV_CLASS(HV_CLASS), .VW(VW),
  .SCALE_W(SCALE_W)) u_sva (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
  .bus_volt(bus_volt), .ctrl_power_ok(ctrl_power_ok), .run_cmd(run_cmd),
  .drive_err(drive_err), .output_block_q(output_block_q), .volt_scale_q(volt_scale_q),
  .bus_undervoltage_q(bus_undervoltage_q), .bus_undervoltage_fault_q(bus_undervoltage_fault_q),
  .err_out_q(err_out_q), .irq_q(irq_q));

// File: tb/plr_supply_model.sv
`timescale 1ns/100ps
module plr_supply_model (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Scenario controls
  input wire loss,
  input wire run_req,
  input wire ctrl_loss,
  // Supply side
  output reg [9:0] bus_volt,
  output reg ctrl_power_ok,
  output reg run_cmd
);
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // Bus already charged so release shows no false outage
      bus_volt <= 10'h12c;
      ctrl_power_ok <= 1'b0;
      run_cmd <= 1'b0;
    end else begin
      // Outage sags the bus well under the lowest threshold
      bus_volt <= loss ? 10'h064 : 10'h12c;
      ctrl_power_ok <= !ctrl_loss;
      // Command stays latched through the outage so the drive can resume
      run_cmd <= run_req;
    end
  end
endmodule // plr_supply_model

// File: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  reg clk = 1'b0;
  reg arst_n = 1'b0;
  reg [3:0] reg_addr = 4'h0;
  reg [15:0] reg_wdata = 16'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg drive_err = 1'b0;
  reg loss = 1'b0;
  reg run_req = 1'b0;
  reg ctrl_loss = 1'b0;
  wire [9:0] bus_volt;
  wire ctrl_power_ok;
  wire run_cmd;
  wire [15:0] reg_rdata_q;
  wire output_block_q;
  wire [7:0] volt_scale_q;
  wire bus_undervoltage_q;
  wire bus_undervoltage_fault_q;
  wire err_out_q;
  wire irq_q;
  integer err_count = 0;
  integer checks = 0;
  always #5 clk = ~clk;
  plr_supply_model u_sup (.clk(clk), .arst_n(arst_n), .loss(loss), .run_req(run_req),
    .ctrl_loss(ctrl_loss),
    .bus_volt(bus_volt), .ctrl_power_ok(ctrl_power_ok), .run_cmd(run_cmd));
  plr_ctrl #(.TICK_CYCLES(10)) u_dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .bus_volt(bus_volt), .ctrl_power_ok(ctrl_power_ok), .run_cmd(run_cmd),
    .drive_err(drive_err), .output_block_q(output_block_q), .volt_scale_q(volt_scale_q),
    .bus_undervoltage_q(bus_undervoltage_q),
    .bus_undervoltage_fault_q(bus_undervoltage_fault_q), .err_out_q(err_out_q), .irq_q(irq_q));
  // ----------------------------------------
  // Access and check tasks
  // ----------------------------------------
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [15:0] d);
    begin
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [15:0] exp);
    begin
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata_q, exp);
    end
  endtask
  // Full asks for the ramp to reach maximum as well
  task wait_run(input full);
    integer n;
    begin
      n = 0;
      while ((output_block_q !== 1'b0 || (full && volt_scale_q !== 8'hff)) && n < 8000) begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      chk(n < 8000, 16'h1);
    end
  endtask
  task dip(input integer ms, input f);
    begin
      @(posedge clk);
      loss <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk(bus_undervoltage_q, 16'h1);
      repeat (ms * 10) @(posedge clk);
      loss <= 1'b0;
      #1;
      chk(err_out_q, f);
      chk(bus_undervoltage_fault_q, f);
    end
  endtask
  task summarize;
    begin
      if (err_count == 0 && checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    run_req <= 1'b1;
    rd(4'h0, 16'h0000);
    rd(4'h1, 16'h0001);
    rd(4'h2, 16'h0001);
    rd(4'h3, 16'h0003);
    rd(4'h4, 16'h00be);
    wr(4'h0, 16'h0003);
    rd(4'h0, 16'h0000);
    rd(4'h8, 16'h0000);
    wr(4'h1, 16'h003f);
    rd(4'h1, 16'h0014);
    wr(4'h1, 16'h0001);
    wr(4'h7, 16'h0007);
    wait_run(1'b0);
    dip(14, 1'b0);
    wait_run(1'b1);
    chk(irq_q, 16'h1);
    rd(4'h6, 16'h0003);
    wr(4'h6, 16'h0007);
    wr(4'h7, 16'h0000);
    chk(irq_q, 16'h0);
    dip(20, 1'b1);
    repeat (300) @(posedge clk);
    chk(bus_undervoltage_fault_q, 16'h1);
    wr(4'h0, 16'h0011);
    wait_run(1'b0);
    @(posedge clk) drive_err <= 1'b1;
    dip(90, 1'b0);
    wait_run(1'b1);
    @(posedge clk) drive_err <= 1'b0;
    dip(120, 1'b1);
    wr(4'h0, 16'h0012);
    wait_run(1'b0);
    dip(300, 1'b0);
    wait_run(1'b1);
    @(posedge clk) {loss, ctrl_loss} <= 2'b11;
    repeat (20) @(posedge clk);
    rd(4'h5, 16'h00a8);
    @(posedge clk) {loss, ctrl_loss} <= 2'b00;
    wait_run(1'b1);
    summarize;
  end
  initial begin
    repeat (100000) @(posedge clk);
    err_count = err_count + 1;
    summarize;
  end
endmodule // tb_top
